// ===== core/bhr_recorder.sv
// branch history recorder: entry array, last-event record, timer and wishbone registers
//
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
`include "bhr_regs.svh"
`default_nettype none
// Operation
// - privilege zero needs supervisor enable, higher levels need user enable
// - privilege changing operations filter on the ending privilege level
// - filtered source level stores the fixed 000F_FFFF_FFFF_FFFF source pattern
// - capability bit 31 says offset or linear addresses are captured
// - reads are canonical; top-of-lower-half fault stores lowest upper address
// - address writes never fault, sign-extend, undefined bits read zero
// - branch kind is a four-bit code passed into the info field
// - saturating cycle timer copied into entry then restarted on record
// - valid flag marks a real elapsed count, saturating at FFFF
// - large counts may force low bits to one, error under ten percent
// - mispredicted flag for wrong direction or wrong indirect target
// - in-transaction and transaction-abort flags stored per entry
// - management interrupt saves and clears enable; resume restores it
// - resume recorded only without freeze, with source equal to target
// - machine exit saves guest control; entry bit 21 loads, exit bit 26 clears
// - guest load fails the entry check when reserved control bits are set
// - enclave entry suspends recording, exit resumes; debug enclaves unaffected
// - debug exception branch clears enable and is not recorded
// - secure launch and authenticated code leaves clear the whole control
// - deep sleep clears entries only; shallow sleep keeps everything
// - sample count limited to depth, record size and format follow
// - warm reset clears enable only; warm reset from C6 reinitialises all
// - nothing but a resume is captured while the recording enable is zero
// - any depth write zeroes all entries but not the last-event record
module bhr_recorder #(
  parameter int N_ENTRIES   = 8,
  parameter int MAXLIN      = 48,
  parameter bit LINEAR_IP   = 1'b1
) (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic [31:0]              wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic                ret_valid,
  input  wire bhr_pkg::bhr_retire_s ret,
  input  wire bhr_pkg::bhr_power_s pwr,
  output logic                     vm_entry_fail,
  output logic                     recording_active
);
  localparam int DW = $clog2(N_ENTRIES + 1);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // refused at elaboration: index width and sign-extension assume these ranges
  if (N_ENTRIES < 1 || N_ENTRIES > 31 || MAXLIN < 33 || MAXLIN > 63) begin : g_bad_cfg
    $error("bhr_recorder: unsupported parameters");
  end

  logic [63:0] src_mem [N_ENTRIES];
  logic [63:0] tgt_mem [N_ENTRIES];
  logic [31:0] info_mem [N_ENTRIES];
  logic [63:0] ler_src_reg, ler_tgt_reg;
  logic [31:0] ler_info_reg;
  logic [31:0] ctl_reg, guest_ctl_reg, vmctl_reg, scfg_reg, dbg_reg;
  logic [DW-1:0] depth_reg;
  logic [5:0]  sel_reg;
  logic        saved_en_reg, encl_susp_reg, timer_valid_reg;
  logic [15:0] cyc_reg;
  logic        ack_reg;
  logic [31:0] dat_reg;
  logic        fail_reg;

  function automatic logic [63:0] canon(input logic [63:0] a);
    canon = {{(64 - MAXLIN){a[MAXLIN-1]}}, a[MAXLIN-1:0]};
  endfunction

  // bus: registered ack one cycle after the request, writes land on the ack edge
  logic bus_req, bus_wr;
  assign bus_req = wb_cyc_i && wb_stb_i;
  assign bus_wr  = bus_req && wb_we_i && ack_reg && (wb_sel_i == 4'hF);

  function automatic logic wr_at(input logic [7:0] ofs);
    wr_at = bus_wr && (wb_adr_i == ofs);
  endfunction

  // event decode
  logic ev_ok, op_branch, op_resume, op_encout, priv_ok, push, push_ler;
  logic clr_entries, init_all;
  logic [63:0] cap_src, cap_tgt;
  logic [15:0] cyc_cap;
  logic [31:0] cap_info;

  assign ev_ok     = ret_valid;
  assign op_branch = ev_ok && ret.op == bhr_pkg::BHR_OP_BRANCH;
  assign op_resume = ev_ok && ret.op == bhr_pkg::BHR_OP_RESUME;
  assign op_encout = ev_ok && ret.op == bhr_pkg::BHR_OP_ENCOUT;
  assign init_all  = pwr.warm && pwr.warm_c6;
  assign clr_entries = wr_at(`BHR_OFS_DEPTH) || (pwr.req && pwr.deep);

  function automatic logic lvl_en(input logic [1:0] lvl, input logic [31:0] c);
    lvl_en = (lvl == 2'd0) ? c[`BHR_CTL_SUP] : c[`BHR_CTL_USR];
  endfunction

  // the ending level decides, so a call gate into level zero is judged as level zero
  assign priv_ok = lvl_en(ret.current_privilege_level, ctl_reg);

  // resume is judged against the enable it restores
  always_comb begin
    push = 1'b0;
    if (!init_all && !clr_entries && !pwr.warm) begin
      if (op_resume)
        push = saved_en_reg && !dbg_reg[`BHR_DBG_FREEZE] && priv_ok;
      else if (op_branch || op_encout)
        push = ctl_reg[`BHR_CTL_EN] && priv_ok
               && (!encl_susp_reg || op_encout);
    end
  end
  assign push_ler = push && ret.is_event;

  // large counts are coarsened: low bits forced to one
  always_comb begin
    cyc_cap = cyc_reg;
    if (cyc_reg >= `BHR_CYC_COARSE_AT)
      cyc_cap[`BHR_CYC_COARSE_BITS-1:0] = '1;
  end

  always_comb begin
    cap_tgt = canon(ret.tgt);
    if (op_resume)
      cap_src = cap_tgt;
    else if (!lvl_en(ret.prev_cpl, ctl_reg))
      cap_src = `BHR_FILTERED_SRC;
    else if (ret.seq_top_fault)
      cap_src = {{(65 - MAXLIN){1'b1}}, {(MAXLIN - 1){1'b0}}};
    else
      cap_src = canon(ret.src);
    cap_info = '0;
    cap_info[`BHR_INFO_CYC_HI:0] = cyc_cap;
    cap_info[`BHR_INFO_KIND_LO +: 4] = ret.kind;
    cap_info[`BHR_INFO_ABORT] = ret.tx_abort;
    cap_info[`BHR_INFO_INTX]  = ret.in_tx;
    cap_info[`BHR_INFO_MISP]  = ret.mispredicted_flag;
    cap_info[`BHR_INFO_VALID] = timer_valid_reg;
  end

  // software access to the selected entry
  logic ent_sel_ok;
  assign ent_sel_ok = ({2'b00, sel_reg} < 8'(depth_reg));

  function automatic logic [63:0] put_lo(input logic [63:0] a, input logic [31:0] d);
    put_lo = canon({a[63:32], d});
  endfunction
  function automatic logic [63:0] put_hi(input logic [63:0] a, input logic [31:0] d);
    put_hi = canon({d, a[31:0]}); // upper bits ignored, re-extended
  endfunction

  // one shifting slot per entry; record beats software write
  for (genvar gi = 0; gi < N_ENTRIES; gi++) begin : g_ent
    localparam logic [5:0] IDX = 6'(gi);
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        src_mem[gi]  <= '0;
        tgt_mem[gi]  <= '0;
        info_mem[gi] <= '0;
      end else if (init_all || clr_entries) begin
        src_mem[gi]  <= '0;
        tgt_mem[gi]  <= '0;
        info_mem[gi] <= '0;
      end else if (push) begin
        if (gi == 0) begin
          src_mem[gi]  <= cap_src;
          tgt_mem[gi]  <= cap_tgt;
          info_mem[gi] <= cap_info;
        end else if (DW'(gi) < depth_reg) begin
          src_mem[gi]  <= src_mem[(gi == 0) ? 0 : gi - 1];
          tgt_mem[gi]  <= tgt_mem[(gi == 0) ? 0 : gi - 1];
          info_mem[gi] <= info_mem[(gi == 0) ? 0 : gi - 1];
        end
      end else if (sel_reg == IDX && ent_sel_ok) begin
        if (wr_at(`BHR_OFS_SRC_LO)) src_mem[gi] <= put_lo(src_mem[gi], wb_dat_i);
        if (wr_at(`BHR_OFS_SRC_HI)) src_mem[gi] <= put_hi(src_mem[gi], wb_dat_i);
        if (wr_at(`BHR_OFS_TGT_LO)) tgt_mem[gi] <= put_lo(tgt_mem[gi], wb_dat_i);
        if (wr_at(`BHR_OFS_TGT_HI)) tgt_mem[gi] <= put_hi(tgt_mem[gi], wb_dat_i);
        if (wr_at(`BHR_OFS_INFO))   info_mem[gi] <= wb_dat_i & 32'hF000_FFFF | 32'h0F00_0000 & wb_dat_i;
      end
    end
  end

  // last-event record survives depth writes and deep sleep
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ler_src_reg  <= '0;
      ler_tgt_reg  <= '0;
      ler_info_reg <= '0;
    end else if (init_all) begin
      ler_src_reg  <= '0;
      ler_tgt_reg  <= '0;
      ler_info_reg <= '0;
    end else if (push_ler) begin
      ler_src_reg  <= cap_src;
      ler_tgt_reg  <= cap_tgt;
      ler_info_reg <= cap_info;
    end else if (sel_reg == `BHR_SEL_LER) begin
      if (wr_at(`BHR_OFS_SRC_LO)) ler_src_reg <= put_lo(ler_src_reg, wb_dat_i);
      if (wr_at(`BHR_OFS_SRC_HI)) ler_src_reg <= put_hi(ler_src_reg, wb_dat_i);
      if (wr_at(`BHR_OFS_TGT_LO)) ler_tgt_reg <= put_lo(ler_tgt_reg, wb_dat_i);
      if (wr_at(`BHR_OFS_TGT_HI)) ler_tgt_reg <= put_hi(ler_tgt_reg, wb_dat_i);
      if (wr_at(`BHR_OFS_INFO))   ler_info_reg <= wb_dat_i & 32'hFF00_FFFF;
    end
  end

  // cycle timer runs through enclaves and suspension
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cyc_reg         <= '0;
      timer_valid_reg <= 1'b0;
    end else if (init_all) begin
      cyc_reg         <= '0;
      timer_valid_reg <= 1'b0;
    end else if (push) begin
      cyc_reg         <= '0;
      timer_valid_reg <= 1'b1;
    end else if (cyc_reg != `BHR_CYC_MAX) begin
      cyc_reg <= cyc_reg + 16'h0001;
    end
  end

  // control: hardware events win over a software write in the same cycle
  logic guest_ok;
  assign guest_ok = (guest_ctl_reg & ~`BHR_CTL_MASK) == 32'h0000_0000;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctl_reg       <= '0;
      saved_en_reg  <= 1'b0;
      guest_ctl_reg <= '0;
      fail_reg      <= 1'b0;
    end else begin
      fail_reg <= 1'b0;
      if (init_all) begin
        ctl_reg       <= '0;
        saved_en_reg  <= 1'b0;
        guest_ctl_reg <= '0;
      end else if (pwr.warm) begin
        ctl_reg[`BHR_CTL_EN] <= 1'b0;
      end else if (ev_ok && ret.op == bhr_pkg::BHR_OP_MGMT) begin
        saved_en_reg         <= ctl_reg[`BHR_CTL_EN];
        ctl_reg[`BHR_CTL_EN] <= 1'b0;
      end else if (op_resume) begin
        ctl_reg[`BHR_CTL_EN] <= saved_en_reg;
      end else if (ev_ok && ret.op == bhr_pkg::BHR_OP_DEBUG) begin
        ctl_reg[`BHR_CTL_EN] <= 1'b0;
      end else if (ev_ok && ret.op == bhr_pkg::BHR_OP_SECURE) begin
        ctl_reg <= '0;
      end else if (ev_ok && ret.op == bhr_pkg::BHR_OP_VMEXIT) begin
        guest_ctl_reg <= ctl_reg;
        if (vmctl_reg[`BHR_VM_CLEAR]) ctl_reg <= '0;
      end else if (ev_ok && ret.op == bhr_pkg::BHR_OP_VMENTR) begin
        if (vmctl_reg[`BHR_VM_LOAD]) begin
          if (guest_ok) ctl_reg <= guest_ctl_reg;
          else fail_reg <= 1'b1;
        end
      end else begin
        if (wr_at(`BHR_OFS_CTL))   ctl_reg <= wb_dat_i & `BHR_CTL_MASK;
        if (wr_at(`BHR_OFS_GUEST)) guest_ctl_reg <= wb_dat_i;
      end
    end
  end

  // enclave suspension
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      encl_susp_reg <= 1'b0;
    end else if (init_all) begin
      encl_susp_reg <= 1'b0;
    end else if (ev_ok && ret.op == bhr_pkg::BHR_OP_ENCIN && !ret.dbg_enclave) begin
      encl_susp_reg <= 1'b1;
    end else if (op_encout) begin
      encl_susp_reg <= 1'b0;
    end
  end

  // configuration registers; depth write clears entries elsewhere
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      depth_reg <= DW'(N_ENTRIES);
      sel_reg   <= '0;
      dbg_reg   <= '0;
      vmctl_reg <= '0;
      scfg_reg  <= '0;
    end else if (init_all) begin
      depth_reg <= DW'(N_ENTRIES);
      sel_reg   <= '0;
      dbg_reg   <= '0;
      vmctl_reg <= '0;
      scfg_reg  <= '0;
    end else begin
      if (wr_at(`BHR_OFS_DEPTH) && wb_dat_i != 32'h0 && wb_dat_i <= 32'(N_ENTRIES))
        depth_reg <= DW'(wb_dat_i);
      if (wr_at(`BHR_OFS_SEL))    sel_reg <= wb_dat_i[5:0];
      if (wr_at(`BHR_OFS_DBGCTL)) dbg_reg <= {31'h0, wb_dat_i[`BHR_DBG_FREEZE]};
      if (wr_at(`BHR_OFS_VMCTL))
        vmctl_reg <= wb_dat_i & (32'h1 << `BHR_VM_LOAD | 32'h1 << `BHR_VM_CLEAR);
      if (wr_at(`BHR_OFS_SCFG))
        scfg_reg <= wb_dat_i & 32'h1F00_0008;
    end
  end

  // sample record sizing limited by the active depth
  logic [4:0]  samp_req, samp_eff;
  logic [15:0] samp_size;
  assign samp_req  = scfg_reg[`BHR_SCFG_NUM_HI:`BHR_SCFG_NUM_LO];
  assign samp_eff  = (8'(samp_req) > 8'(depth_reg)) ? 5'(depth_reg) : samp_req;
  assign samp_size = `BHR_REC_BASE
                   + (scfg_reg[`BHR_SCFG_EN] ? 16'(samp_eff) * `BHR_ENTRY_BYTES : 16'h0);

  // read mux
  logic [63:0] rd_src, rd_tgt;
  logic [31:0] rd_info, rd_word;
  always_comb begin
    rd_src  = '0;
    rd_tgt  = '0;
    rd_info = '0;
    if (sel_reg == `BHR_SEL_LER) begin
      rd_src  = ler_src_reg;
      rd_tgt  = ler_tgt_reg;
      rd_info = ler_info_reg;
    end else if (ent_sel_ok) begin
      rd_src  = src_mem[sel_reg[$clog2(N_ENTRIES+1)-1:0] % N_ENTRIES];
      rd_tgt  = tgt_mem[sel_reg[$clog2(N_ENTRIES+1)-1:0] % N_ENTRIES];
      rd_info = info_mem[sel_reg[$clog2(N_ENTRIES+1)-1:0] % N_ENTRIES];
    end
    if (wb_adr_i == `BHR_OFS_CTL)         rd_word = ctl_reg;
    else if (wb_adr_i == `BHR_OFS_DEPTH)  rd_word = 32'(depth_reg);
    else if (wb_adr_i == `BHR_OFS_DBGCTL)
      rd_word = dbg_reg | (32'(LINEAR_IP) << `BHR_DBG_LINIP);
    else if (wb_adr_i == `BHR_OFS_SEL)    rd_word = 32'(sel_reg);
    else if (wb_adr_i == `BHR_OFS_SRC_LO) rd_word = rd_src[31:0];
    else if (wb_adr_i == `BHR_OFS_SRC_HI) rd_word = rd_src[63:32];
    else if (wb_adr_i == `BHR_OFS_TGT_LO) rd_word = rd_tgt[31:0];
    else if (wb_adr_i == `BHR_OFS_TGT_HI) rd_word = rd_tgt[63:32];
    else if (wb_adr_i == `BHR_OFS_INFO)   rd_word = rd_info;
    else if (wb_adr_i == `BHR_OFS_GUEST)  rd_word = guest_ctl_reg;
    else if (wb_adr_i == `BHR_OFS_VMCTL)  rd_word = vmctl_reg;
    else if (wb_adr_i == `BHR_OFS_SCFG)   rd_word = scfg_reg;
    else if (wb_adr_i == `BHR_OFS_SOUT)
      rd_word = {3'b000, samp_eff, 8'h00, samp_size};
    else if (wb_adr_i == `BHR_OFS_STATUS)
      rd_word = {29'h0, encl_susp_reg, saved_en_reg, timer_valid_reg};
    else                                  rd_word = 32'h0000_0000;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
      dat_reg <= '0;
    end else begin
      ack_reg <= bus_req && !ack_reg;
      if (bus_req && !ack_reg) dat_reg <= rd_word;
    end
  end

  assign wb_ack_o         = ack_reg;
  assign wb_dat_o         = dat_reg;
  assign vm_entry_fail    = fail_reg;
  assign recording_active = ctl_reg[`BHR_CTL_EN] && !encl_susp_reg;

  a_disabled_nocap: assert property (
    !ctl_reg[`BHR_CTL_EN] && !op_resume |-> !push)
    else $error("entry captured while disabled");
  a_priv_filter: assert property (
    push && ret.current_privilege_level == 2'd0 && !op_resume |-> ctl_reg[`BHR_CTL_SUP])
    else $error("level zero recorded without supervisor enable");
  a_filtered_src: assert property (
    push && !op_resume && !lvl_en(ret.prev_cpl, ctl_reg)
    |=> src_mem[0] == `BHR_FILTERED_SRC)
    else $error("filtered source pattern missing");
  a_depth_clears: assert property (
    wr_at(`BHR_OFS_DEPTH) |=> info_mem[0] == 32'h0 && src_mem[0] == 64'h0
                              && $stable(ler_info_reg))
    else $error("depth write did not clear entries");
  a_mgmt_clear: assert property (
    ev_ok && ret.op == bhr_pkg::BHR_OP_MGMT && !pwr.warm
    |=> !ctl_reg[`BHR_CTL_EN] && saved_en_reg == $past(ctl_reg[`BHR_CTL_EN]))
    else $error("management interrupt did not save and clear");
  a_resume_src: assert property (
    push && op_resume |=> src_mem[0] == tgt_mem[0])
    else $error("resume source differs from target");
  a_debug_clear: assert property (
    ev_ok && ret.op == bhr_pkg::BHR_OP_DEBUG && !pwr.warm
    |-> !push ##1 !ctl_reg[`BHR_CTL_EN])
    else $error("debug exception left recording on");
  a_secure_clear: assert property (
    ev_ok && ret.op == bhr_pkg::BHR_OP_SECURE && !pwr.warm |=> ctl_reg == 32'h0)
    else $error("secure leaf did not clear control");
  a_timer_copy: assert property (
    push && !clr_entries |=> info_mem[0][15:0] == $past(cyc_cap) && cyc_reg == 16'h0)
    else $error("timer not copied and restarted");
  a_timer_sat: assert property (
    cyc_reg == `BHR_CYC_MAX && !push && !init_all |=> cyc_reg == `BHR_CYC_MAX)
    else $error("timer wrapped");
  a_guest_fail: assert property (
    ev_ok && ret.op == bhr_pkg::BHR_OP_VMENTR && vmctl_reg[`BHR_VM_LOAD] && !guest_ok
    && !pwr.warm |=> vm_entry_fail && $stable(ctl_reg))
    else $error("bad guest control was loaded");
endmodule
`default_nettype wire

// ===== include/bhr_pkg.sv
// types shared by the branch history recorder
`default_nettype none
package bhr_pkg;
  typedef enum logic [3:0] {
    BHR_OP_NONE   = 4'h0,
    BHR_OP_BRANCH = 4'h1,
    BHR_OP_MGMT   = 4'h3,
    BHR_OP_RESUME = 4'h2,
    BHR_OP_DEBUG  = 4'h6,
    BHR_OP_SECURE = 4'h7,
    BHR_OP_VMEXIT = 4'h5,
    BHR_OP_VMENTR = 4'h4,
    BHR_OP_ENCIN  = 4'hC,
    BHR_OP_ENCOUT = 4'hD
  } bhr_op_e;

  typedef struct packed {
    bhr_op_e     op;
    logic [3:0]  kind;
    logic [63:0] src;
    logic [63:0] tgt;
    logic [1:0]  current_privilege_level;
    logic [1:0]  prev_cpl;
    logic        mispredicted_flag;
    logic        in_tx;
    logic        tx_abort;
    logic        seq_top_fault;
    logic        dbg_enclave;
    logic        is_event;
  } bhr_retire_s;

  typedef struct packed {
    logic       req;
    logic       deep;
    logic       warm;
    logic       warm_c6;
  } bhr_power_s;
endpackage
`default_nettype wire

// ===== include/bhr_regs.svh
// register offsets, field positions and constants of the branch history recorder
`ifndef BHR_REGS_SVH
`define BHR_REGS_SVH
`define BHR_OFS_CTL       8'h00
`define BHR_OFS_DEPTH     8'h04
`define BHR_OFS_DBGCTL    8'h08
`define BHR_OFS_SEL       8'h0C
`define BHR_OFS_SRC_LO    8'h10
`define BHR_OFS_SRC_HI    8'h14
`define BHR_OFS_TGT_LO    8'h18
`define BHR_OFS_TGT_HI    8'h1C
`define BHR_OFS_INFO      8'h20
`define BHR_OFS_GUEST     8'h24
`define BHR_OFS_VMCTL     8'h28
`define BHR_OFS_SCFG      8'h2C
`define BHR_OFS_SOUT      8'h30
`define BHR_OFS_STATUS    8'h34
`define BHR_CTL_EN        0
`define BHR_CTL_SUP       1
`define BHR_CTL_USR       2
`define BHR_CTL_MASK      32'h0000_0007
`define BHR_DBG_FREEZE    0
`define BHR_DBG_LINIP     31
`define BHR_VM_LOAD       21
`define BHR_VM_CLEAR      26
`define BHR_SCFG_EN       3
`define BHR_SCFG_NUM_HI   28
`define BHR_SCFG_NUM_LO   24
`define BHR_INFO_CYC_HI   15
`define BHR_INFO_KIND_LO  24
`define BHR_INFO_ABORT    28
`define BHR_INFO_INTX     29
`define BHR_INFO_MISP     30
`define BHR_INFO_VALID    31
`define BHR_SEL_LER       6'h3F
`define BHR_FILTERED_SRC  64'h000F_FFFF_FFFF_FFFF
`define BHR_CYC_MAX       16'hFFFF
`define BHR_CYC_COARSE_AT 16'h1000
`define BHR_CYC_COARSE_BITS 4
`define BHR_ENTRY_BYTES   16'h0018
`define BHR_REC_BASE      16'h0010
`endif

// ===== verif/bhr_core_model.sv
// retirement-side model: presents one retired operation per call
`default_nettype none
module bhr_core_model (
  input  wire logic            mclk,
  output var logic             ret_valid,
  output var bhr_pkg::bhr_retire_s ret
);
  initial begin
    ret_valid = 1'b0;
    ret       = '0;
  end
  // gap idles the core; idle fields are inverted so stale values never look valid
  task automatic issue(input bhr_pkg::bhr_retire_s r, input int gap);
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    ret_valid <= 1'b1;
    ret       <= r;
    @(posedge mclk);
    ret_valid <= 1'b0;
    ret       <= bhr_pkg::bhr_retire_s'(~r);
  endtask
endmodule
`default_nettype wire

// ===== verif/test_branch_history_recorder.sv
// self-checking bench for the branch history recorder
`include "bhr_regs.svh"
`default_nettype none
module test_branch_history_recorder;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 mclk = 1'b0;
  logic                 rst = 1'b1;
  logic                 cyc = 1'b0;
  logic                 stb = 1'b0;
  logic                 we = 1'b0;
  logic [7:0]           adr = 8'h00;
  logic [3:0]           sel = 4'hF;
  logic [31:0]          dat = 32'h0000_0000;
  logic [31:0]          dat_o;
  logic [31:0]          rdat;
  logic                 ack;
  logic                 vfail;
  logic                 act;
  logic                 fail_seen = 1'b0;
  logic                 ret_valid;
  bhr_pkg::bhr_retire_s ret;
  bhr_pkg::bhr_retire_s r;
  bhr_pkg::bhr_power_s  pwr = 4'h0;
  int                   n_mismatch = 0;
  int                   check_count = 0;

  always #12.5 mclk = ~mclk;
  always @(posedge mclk) if (vfail === 1'b1) fail_seen <= 1'b1;

  bhr_recorder dut (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .ret_valid(ret_valid), .ret(ret), .pwr(pwr), .vm_entry_fail(vfail),
    .recording_active(act));
  bhr_core_model core (.mclk(mclk), .ret_valid(ret_valid), .ret(ret));

  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // holds the request until ack is sampled; a dead slave ends the run
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_mismatch++;
      complete_run();
    end
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk(64'(rdat), 64'(e));
  endtask

  task automatic rd_ent(input logic [7:0] lo, input logic [63:0] e);
    logic [31:0] h;
    wb(1'b0, lo + 8'h04, 32'h0000_0000);
    h = rdat;
    wb(1'b0, lo, 32'h0000_0000);
    chk({h, rdat}, e);
  endtask

  task automatic pulse(input logic [3:0] v);
    @(posedge mclk);
    pwr <= v;
    @(posedge mclk);
    pwr <= 4'h0;
  endtask

  function automatic bhr_pkg::bhr_retire_s mk(input bhr_pkg::bhr_op_e op,
      input logic [3:0] k, input logic [1:0] c, input logic [1:0] p);
    mk = '0;
    mk.op = op;
    mk.kind = k;
    mk.src = 64'h0000_1234_5678_9AB0 + 64'(k);
    mk.tgt = 64'hFFFF_8000_0000_1000 + 64'(k);
    mk.current_privilege_level = c;
    mk.prev_cpl = p;
  endfunction

  task automatic t_reset();
    rd(`BHR_OFS_CTL, 32'h0000_0000);
    rd(`BHR_OFS_DEPTH, 32'h0000_0008);
    wb(1'b0, `BHR_OFS_DBGCTL, 32'h0000_0000);
    chk(64'(rdat[31]), 64'h0000_0000_0000_0001);
    rd(8'hFC, 32'h0000_0000);
  endtask

  task automatic t_filter();
    logic [3:0] kinds [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'hF};
    wb(1'b1, `BHR_OFS_SEL, 32'h0000_0000);
    core.issue(mk(bhr_pkg::BHR_OP_BRANCH, 4'h2, 2'd3, 2'd3), 0);
    rd_ent(`BHR_OFS_SRC_LO, 64'h0000_0000_0000_0000);
    wb(1'b1, `BHR_OFS_CTL, 32'h0000_0005);
    core.issue(mk(bhr_pkg::BHR_OP_BRANCH, 4'h2, 2'd3, 2'd3), 0);
    rd_ent(`BHR_OFS_SRC_LO, mk(bhr_pkg::BHR_OP_BRANCH, 4'h2, 2'd3, 2'd3).src);
    core.issue(mk(bhr_pkg::BHR_OP_BRANCH, 4'h4, 2'd0, 2'd0), 0);
    rd_ent(`BHR_OFS_TGT_LO, mk(bhr_pkg::BHR_OP_BRANCH, 4'h2, 2'd3, 2'd3).tgt);
    core.issue(mk(bhr_pkg::BHR_OP_BRANCH, 4'h8, 2'd3, 2'd0), 0);
    rd_ent(`BHR_OFS_SRC_LO, `BHR_FILTERED_SRC);
    core.issue(mk(bhr_pkg::BHR_OP_BRANCH, 4'h9, 2'd0, 2'd3), 0);
    rd_ent(`BHR_OFS_TGT_LO, mk(bhr_pkg::BHR_OP_BRANCH, 4'h8, 2'd3, 2'd0).tgt);
    r = mk(bhr_pkg::BHR_OP_BRANCH, 4'h8, 2'd3, 2'd3);
    r.src = 64'h0000_7FFF_FFFF_FFFF;
    r.seq_top_fault = 1'b1;
    core.issue(r, 0);
    rd_ent(`BHR_OFS_SRC_LO, 64'hFFFF_8000_0000_0000);
    foreach (kinds[i]) begin
      core.issue(mk(bhr_pkg::BHR_OP_BRANCH, kinds[i], 2'd3, 2'd3), 0);
      wb(1'b0, `BHR_OFS_INFO, 32'h0000_0000);
      chk(64'(rdat[27:24]), 64'(kinds[i]));
    end
  endtask

  task automatic t_info();
    r = mk(bhr_pkg::BHR_OP_BRANCH, 4'h0, 2'd3, 2'd3);
    r.mispredicted_flag = 1'b1;
    r.in_tx = 1'b1;
    core.issue(r, 0);
    r.mispredicted_flag = 1'b0;
    r.in_tx = 1'b0;
    r.tx_abort = 1'b1;
    core.issue(r, 5);
    wb(1'b0, `BHR_OFS_INFO, 32'h0000_0000);
    chk(64'(rdat[31:28]), 64'h0000_0000_0000_0009);
    chk(64'(rdat[15:0] inside {[16'h0006:16'h0007]}), 64'h0000_0000_0000_0001);
    wb(1'b1, `BHR_OFS_SEL, 32'h0000_0001);
    wb(1'b0, `BHR_OFS_INFO, 32'h0000_0000);
    chk(64'(rdat[30:28]), 64'h0000_0000_0000_0006);
    wb(1'b1, `BHR_OFS_SEL, 32'h0000_0000);
    core.issue(r, 0);
    core.issue(r, 4200);
    wb(1'b0, `BHR_OFS_INFO, 32'h0000_0000);
    chk(64'(rdat[15:0]), 64'h106F);
    core.issue(r, 70000);
    wb(1'b0, `BHR_OFS_INFO, 32'h0000_0000);
    chk(64'(rdat[15:0]), 64'h0000_0000_0000_FFFF);
  endtask

  task automatic t_mode();
    core.issue(mk(bhr_pkg::BHR_OP_MGMT, 4'h8, 2'd0, 2'd3), 0);
    rd(`BHR_OFS_CTL, 32'h0000_0004);
    r = mk(bhr_pkg::BHR_OP_RESUME, 4'h8, 2'd3, 2'd3);
    core.issue(r, 0);
    rd(`BHR_OFS_CTL, 32'h0000_0005);
    rd_ent(`BHR_OFS_SRC_LO, r.tgt);
    wb(1'b1, `BHR_OFS_DBGCTL, 32'h0000_0001);
    core.issue(mk(bhr_pkg::BHR_OP_MGMT, 4'h8, 2'd0, 2'd3), 0);
    core.issue(mk(bhr_pkg::BHR_OP_RESUME, 4'hA, 2'd3, 2'd3), 0);
    rd_ent(`BHR_OFS_TGT_LO, r.tgt);
    wb(1'b1, `BHR_OFS_DBGCTL, 32'h0000_0000);
    core.issue(mk(bhr_pkg::BHR_OP_DEBUG, 4'h8, 2'd3, 2'd3), 0);
    rd(`BHR_OFS_CTL, 32'h0000_0004);
    wb(1'b1, `BHR_OFS_CTL, 32'h0000_0005);
    core.issue(mk(bhr_pkg::BHR_OP_SECURE, 4'h8, 2'd3, 2'd3), 0);
    rd(`BHR_OFS_CTL, 32'h0000_0000);
    wb(1'b1, `BHR_OFS_CTL, 32'h0000_0005);
    wb(1'b1, `BHR_OFS_VMCTL, 32'h0400_0000);
    core.issue(mk(bhr_pkg::BHR_OP_VMEXIT, 4'h8, 2'd0, 2'd3), 0);
    rd(`BHR_OFS_GUEST, 32'h0000_0005);
    rd(`BHR_OFS_CTL, 32'h0000_0000);
    wb(1'b1, `BHR_OFS_VMCTL, 32'h0020_0000);
    core.issue(mk(bhr_pkg::BHR_OP_VMENTR, 4'h8, 2'd3, 2'd0), 0);
    rd(`BHR_OFS_CTL, 32'h0000_0005);
    wb(1'b1, `BHR_OFS_GUEST, 32'h0000_0105);
    core.issue(mk(bhr_pkg::BHR_OP_VMENTR, 4'h8, 2'd3, 2'd0), 0);
    rd(`BHR_OFS_CTL, 32'h0000_0005);
    chk(64'(fail_seen), 64'h0000_0000_0000_0001);
    wb(1'b1, `BHR_OFS_VMCTL, 32'h0000_0000);
  endtask

  task automatic t_power();
    r = mk(bhr_pkg::BHR_OP_BRANCH, 4'h1, 2'd3, 2'd3);
    core.issue(r, 0);
    pulse(4'hC);
    rd_ent(`BHR_OFS_SRC_LO, 64'h0000_0000_0000_0000);
    rd(`BHR_OFS_CTL, 32'h0000_0005);
    core.issue(r, 0);
    pulse(4'h8);
    rd_ent(`BHR_OFS_SRC_LO, r.src);
    pulse(4'h2);
    rd(`BHR_OFS_CTL, 32'h0000_0004);
    rd_ent(`BHR_OFS_SRC_LO, r.src);
    wb(1'b1, `BHR_OFS_DEPTH, 32'h0000_0004);
    rd_ent(`BHR_OFS_SRC_LO, 64'h0000_0000_0000_0000);
    pulse(4'h3);
    rd(`BHR_OFS_DEPTH, 32'h0000_0008);
    wb(1'b1, `BHR_OFS_SRC_HI, 32'hABCD_8000);
    rd(`BHR_OFS_SRC_HI, 32'hFFFF_8000);
    wb(1'b1, `BHR_OFS_SCFG, 32'h1F00_0008);
    wb(1'b0, `BHR_OFS_SOUT, 32'h0000_0000);
    chk(64'(rdat[28:24]), 64'h0000_0000_0000_0008);
    chk(64'(rdat[15:0]), 64'h0000_0000_0000_00D0);
  endtask

  task automatic t_encl();
    wb(1'b1, `BHR_OFS_CTL, 32'h0000_0005);
    core.issue(mk(bhr_pkg::BHR_OP_ENCIN, 4'h8, 2'd3, 2'd3), 0);
    core.issue(mk(bhr_pkg::BHR_OP_BRANCH, 4'h2, 2'd3, 2'd3), 0);
    chk(64'(act), 64'h0);
    rd_ent(`BHR_OFS_TGT_LO, 64'h0);
    r = mk(bhr_pkg::BHR_OP_ENCOUT, 4'h8, 2'd3, 2'd3);
    r.is_event = 1'b1;
    core.issue(r, 0);
    rd(`BHR_OFS_STATUS, 32'h0000_0001);
    chk(64'(act), 64'h1);
    rd_ent(`BHR_OFS_TGT_LO, r.tgt);
    wb(1'b1, `BHR_OFS_SEL, 32'h0000_003F);
    rd_ent(`BHR_OFS_SRC_LO, r.src);
    r.op = bhr_pkg::BHR_OP_ENCIN;
    r.dbg_enclave = 1'b1;
    core.issue(r, 0);
    rd(`BHR_OFS_STATUS, 32'h0000_0001);
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_filter();
    t_info();
    t_mode();
    t_power();
    t_encl();
    complete_run();
  end
endmodule
`default_nettype wire
